// [core/dsz_decrement_skip_if_zero.sv]
// What this block does
// RULE1 - Match opcode 001011 in top bits; next bit picks destination; low seven address file.
// RULE2 - Subtract one from file value; destination 0 writes working register, 1 writes file.
// RULE3 - Zero result decides the skip; status flags are never touched.
// RULE4 - Zero result discards the fetched next instruction and runs a no-operation cycle.
// RULE5 - One program word; one cycle without skip, two cycles with skip.
// RULE6 - After skip continue two words on; otherwise at the next word.
`timescale 1ns/1ps
`default_nettype none
module dsz_decrement_skip_if_zero
   import dsz_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cycleEn,
   input wire dsz_pkg::dsz_exec_in_s execIn,
   input wire logic [12:0] pcIn,
   output logic [dsz_pkg::ADDR_W-1:0] fileAddr,
   output dsz_pkg::dsz_wb_s wb,
   output logic flushFetch,
   output logic pcLoad,
   output logic [12:0] pcNext,
   output logic statusWe,
   output logic busy
);
   import dsz_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic isDsz;
   logic [DATA_W-1:0] decVal;
   logic isZero;
   assign isDsz = execIn.valid && (execIn.word[OPC_HI:OPC_LO] == OPC_DECSKIP); // [RULE1]
   assign decVal = execIn.fileData - DATA_ONE; // [RULE2]
   assign isZero = (decVal == DATA_ZERO); // [RULE3]

   // ----------------------------------------
   // Execute state
   // ----------------------------------------
   dsz_state_e state_r, state_nxt;
   dsz_wb_s wb_r, wb_nxt;
   logic flush_r, flush_nxt;
   logic pcLoad_r, pcLoad_nxt;
   logic [12:0] pc_r, pc_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic busy_r, busy_nxt;
   logic statusWe_r, statusWe_nxt;
   logic takeDsz;
   assign takeDsz = cycleEn && (state_r == ST_EXEC) && isDsz; // [RULE1]

   always_comb begin
      state_nxt = state_r;
      wb_nxt = '0;
      flush_nxt = 1'b0;
      pcLoad_nxt = 1'b0;
      pc_nxt = pc_r;
      addr_nxt = addr_r;
      statusWe_nxt = 1'h0; // [RULE3]
      if (cycleEn) begin
         case (state_r)
            ST_EXEC: begin
               if (isDsz) begin
                  addr_nxt = execIn.word[ADDR_W-1:0]; // [RULE1]
                  wb_nxt.fileAddr = execIn.word[ADDR_W-1:0];
                  wb_nxt.result = decVal;
                  wb_nxt.wregWe = (execIn.word[DEST_BIT] == DEST_WREG); // [RULE2]
                  wb_nxt.fileWe = (execIn.word[DEST_BIT] != DEST_WREG); // [RULE2]
                  pcLoad_nxt = 1'b1;
                  if (isZero) begin
                     // Fetched word is thrown away; PC jumps past it
                     flush_nxt = 1'b1; // [RULE4]
                     pc_nxt = pcIn + PC_STEP + PC_STEP; // [RULE6]
                     state_nxt = ST_NOP; // [RULE5]
                  end else begin
                     pc_nxt = pcIn + PC_STEP; // [RULE6]
                  end
               end
            end
            ST_NOP: begin
               // Bubble cycle: nothing written
               state_nxt = ST_EXEC; // [RULE5]
            end
            default: state_nxt = ST_EXEC;
         endcase
      end
      // Busy leaves its own flop so the output carries no decode logic
      busy_nxt = (state_nxt == ST_NOP); // [RULE5]
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_EXEC;
         wb_r <= '0;
         flush_r <= 1'b0;
         pcLoad_r <= 1'b0;
         pc_r <= PC_RESET;
         addr_r <= '0;
         busy_r <= 1'h0;
         statusWe_r <= 1'h0;
      end else begin
         state_r <= state_nxt;
         wb_r <= wb_nxt;
         flush_r <= flush_nxt;
         pcLoad_r <= pcLoad_nxt;
         pc_r <= pc_nxt;
         addr_r <= addr_nxt;
         busy_r <= busy_nxt;
         statusWe_r <= statusWe_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign fileAddr = addr_r;
   assign wb = wb_r;
   assign flushFetch = flush_r;
   assign pcLoad = pcLoad_r;
   assign pcNext = pc_r;
   assign busy = busy_r;
   // Flags untouched: the write strobe is tied low in a flop
   assign statusWe = statusWe_r; // [RULE3]

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_decode;
      @(posedge clock) disable iff (!rst_n)
      (cycleEn && state_r == ST_EXEC && isDsz) |=> pcLoad;
   endproperty
   a_decode: assert property (p_decode) else $error("decode missed"); // [RULE1]

   property p_wdest;
      @(posedge clock) disable iff (!rst_n)
      (cycleEn && state_r == ST_EXEC && isDsz) |=>
         (wb.wregWe != wb.fileWe) && wb.result == $past(execIn.fileData) - DATA_ONE;
   endproperty
   a_wdest: assert property (p_wdest) else $error("bad writeback"); // [RULE2]

   property p_noflag;
      @(posedge clock) disable iff (!rst_n) !statusWe;
   endproperty
   a_noflag: assert property (p_noflag) else $error("status written"); // [RULE3]

   property p_flush;
      @(posedge clock) disable iff (!rst_n)
      flushFetch |-> (wb.result == DATA_ZERO) && busy;
   endproperty
   a_flush: assert property (p_flush) else $error("flush without zero"); // [RULE4]

   property p_twocyc;
      @(posedge clock) disable iff (!rst_n)
      (busy && cycleEn) |=> !busy;
   endproperty
   a_twocyc: assert property (p_twocyc) else $error("nop too long"); // [RULE5]

   property p_pcstep;
      @(posedge clock) disable iff (!rst_n)
      takeDsz |=>
         pcNext == $past(pcIn) + (($past(execIn.fileData) == DATA_ONE) ? PC_STEP + PC_STEP : PC_STEP);
   endproperty
   a_pcstep: assert property (p_pcstep) else $error("bad next pc"); // [RULE6]

   property p_skipiff;
      @(posedge clock) disable iff (!rst_n)
      takeDsz |=> flushFetch == ($past(execIn.fileData) == DATA_ONE);
   endproperty
   a_skipiff: assert property (p_skipiff) else $error("skip not tied to zero result"); // [RULE4]

   property p_destmap;
      @(posedge clock) disable iff (!rst_n)
      takeDsz |=> wb.fileWe == $past(execIn.word[DEST_BIT])
         && wb.fileAddr == $past(execIn.word[ADDR_W-1:0]);
   endproperty
   a_destmap: assert property (p_destmap) else $error("wrong destination"); // [RULE2]

   property p_bubble;
      @(posedge clock) disable iff (!rst_n)
      (busy && cycleEn) |=> !pcLoad && !flushFetch && !wb.wregWe && !wb.fileWe;
   endproperty
   a_bubble: assert property (p_bubble) else $error("discarded word executed"); // [RULE4]

   property p_ignore;
      @(posedge clock) disable iff (!rst_n)
      (cycleEn && !busy && !isDsz) |=> !pcLoad && !wb.wregWe && !wb.fileWe;
   endproperty
   a_ignore: assert property (p_ignore) else $error("foreign word executed"); // [RULE1]

   property p_addrhold;
      @(posedge clock) disable iff (!rst_n)
      !takeDsz |=> $stable(fileAddr);
   endproperty
   a_addrhold: assert property (p_addrhold) else $error("file address moved"); // [RULE1]

   property p_pchold;
      @(posedge clock) disable iff (!rst_n)
      !takeDsz |=> $stable(pcNext);
   endproperty
   a_pchold: assert property (p_pchold) else $error("next pc moved"); // [RULE6]

   property p_busyset;
      @(posedge clock) disable iff (!rst_n)
      takeDsz |=> busy == ($past(execIn.fileData) == DATA_ONE);
   endproperty
   a_busyset: assert property (p_busyset) else $error("bubble not matched to skip"); // [RULE5]

   property p_nophold;
      @(posedge clock) disable iff (!rst_n)
      (busy && !cycleEn) |=> busy;
   endproperty
   a_nophold: assert property (p_nophold) else $error("bubble lost"); // [RULE5]


   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_skip: cover property (@(posedge clock) disable iff (!rst_n) flushFetch);
   c_noskip: cover property (@(posedge clock) disable iff (!rst_n) pcLoad && !flushFetch);
   c_wreg: cover property (@(posedge clock) disable iff (!rst_n) wb.wregWe);
   c_bubble: cover property (@(posedge clock) disable iff (!rst_n) busy && cycleEn);
   c_filewr: cover property (@(posedge clock) disable iff (!rst_n) wb.fileWe && !flushFetch);
endmodule
`default_nettype wire

// [common/dsz_pkg.sv]
package dsz_pkg;
   // ----------------------------------------
   // Instruction format
   // ----------------------------------------
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int OPC_HI = 13;
   localparam int OPC_LO = 8;
   localparam int DEST_BIT = 7;
   localparam logic [5:0] OPC_DECSKIP = 6'h0b;
   localparam logic DEST_WREG = 1'h0;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [12:0] PC_STEP = 13'h0001;
   localparam logic [12:0] PC_RESET = 13'h0000;

   typedef struct packed {
      logic valid;
      logic [INSN_W-1:0] word;
      logic [DATA_W-1:0] fileData;
   } dsz_exec_in_s;

   typedef struct packed {
      logic wregWe;
      logic fileWe;
      logic [ADDR_W-1:0] fileAddr;
      logic [DATA_W-1:0] result;
   } dsz_wb_s;

   typedef enum logic [0:0] {
      ST_EXEC,
      ST_NOP
   } dsz_state_e;
endpackage

// [bench/test_decrement_skip_if_zero_exec.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_decrement_skip_if_zero_exec;
   import dsz_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cycleEn = 1'b0;
   dsz_exec_in_s execIn = '0;
   logic [12:0] pcIn = 13'h0000;
   logic [ADDR_W-1:0] fileAddr;
   dsz_wb_s wb;
   logic flushFetch;
   logic pcLoad;
   logic [12:0] pcNext;
   logic statusWe;
   logic busy;
   int n_fail = 0;
   int checks = 0;
   always #2.5 clock = ~clock;
   dsz_decrement_skip_if_zero u_dsz_decrement_skip_if_zero (.clock(clock), .rst_n(rst_n), .cycleEn(cycleEn),
      .execIn(execIn), .pcIn(pcIn), .fileAddr(fileAddr), .wb(wb), .flushFetch(flushFetch), .pcLoad(pcLoad),
      .pcNext(pcNext), .statusWe(statusWe), .busy(busy));
   task automatic conclude();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Outputs are registered, so look 1 ns after the taking edge
   task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic [12:0] pc);
      @(posedge clock);
      cycleEn <= 1'b1;
      execIn <= '{1'b1, w, d};
      pcIn <= pc;
      @(posedge clock);
      cycleEn <= 1'b0;
      execIn.valid <= 1'b0;
      #1;
   endtask
   task automatic expect_out(input logic ww, input logic fw, input logic [6:0] a, input logic [7:0] r,
      input logic pl, input logic [12:0] pn, input logic fl, input logic bz);
      `CHK("wregWe", ww, wb.wregWe)
      `CHK("fileWe", fw, wb.fileWe)
      `CHK("statusWe", 1'b0, statusWe)
      `CHK("pcLoad", pl, pcLoad)
      `CHK("flushFetch", fl, flushFetch)
      `CHK("busy", bz, busy)
      if (pl === 1'b1) begin
         `CHK("fileAddr", a, wb.fileAddr)
         `CHK("result", r, wb.result)
         `CHK("pcNext", pn, pcNext)
         `CHK("fileAddrOut", a, fileAddr)
      end
   endtask
   task automatic t_no_skip_wreg();
      issue(14'h0b05, 8'h03, 13'h0010);
      expect_out(1'b1, 1'b0, 7'h05, 8'h02, 1'b1, 13'h0011, 1'b0, 1'b0);
   endtask
   task automatic t_wrap_top_addr();
      issue(14'h0b7f, 8'h00, 13'h1ffe);
      expect_out(1'b1, 1'b0, 7'h7f, 8'hff, 1'b1, 13'h1fff, 1'b0, 1'b0);
   endtask
   // A matching word during the bubble is the discarded one and must do nothing
   task automatic t_skip_file();
      issue(14'h0b85, 8'h01, 13'h000a);
      expect_out(1'b0, 1'b1, 7'h05, 8'h00, 1'b1, 13'h000c, 1'b1, 1'b1);
      issue(14'h0b85, 8'h05, 13'h000b);
      expect_out(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
      `CHK("pcNextHeld", 13'h000c, pcNext)
      `CHK("fileAddrHeld", 7'h05, fileAddr)
      for (int i = 0; i < 4 && busy !== 1'b0; i++) begin
         @(posedge clock);
      end
      if (busy !== 1'b0) begin
         n_fail++;
         conclude();
      end
   endtask
   task automatic t_other_opcode();
      issue(14'h0385, 8'h01, 13'h0020);
      expect_out(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
   endtask
   // Matching word without enable, then enable without valid: both do nothing
   task automatic t_gated();
      @(posedge clock);
      execIn <= '{1'h1, 14'h0b05, 8'h01};
      @(posedge clock);
      execIn.valid <= 1'h0;
      cycleEn <= 1'h1;
      #1;
      expect_out(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
      @(posedge clock);
      cycleEn <= 1'h0;
      #1;
      expect_out(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
   endtask
   // Reset in the bubble must drop the pending no-operation cycle
   task automatic t_reset_bubble();
      issue(14'h0b01, 8'h01, 13'h0040);
      expect_out(1'b1, 1'b0, 7'h01, 8'h00, 1'b1, 13'h0042, 1'b1, 1'b1);
      @(posedge clock);
      rst_n <= 1'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      #1;
      expect_out(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
      `CHK("pcNextReset", 13'h0000, pcNext)
      `CHK("fileAddrReset", 7'h00, fileAddr)
      issue(14'h0b02, 8'h05, 13'h0050);
      expect_out(1'b1, 1'b0, 7'h02, 8'h04, 1'b1, 13'h0051, 1'b0, 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_no_skip_wreg();
      t_wrap_top_addr();
      t_skip_file();
      t_other_opcode();
      t_gated();
      t_reset_bubble();
      t_no_skip_wreg();
      conclude();
   end
endmodule
`default_nettype wire
